// >>> pkg/cpfl_pkg.sv
// Package of constants and types for the charger protection fault logic
package cpfl_pkg;
    // Event indices, one per protection or alarm source
    localparam int EV_ADP1_OV = 0;
    localparam int EV_ADP2_OV = 1;
    localparam int EV_BUS_OV = 2;
    localparam int EV_BUS_OC = 3;
    localparam int EV_BUS_UC = 4;
    localparam int EV_RCP = 5;
    localparam int EV_BUS_OV_ALM = 6;
    localparam int EV_BUS_OC_ALM = 7;
    localparam int EV_BAT_OV = 8;
    localparam int EV_BAT_OV_ALM = 9;
    localparam int EV_BAT_OC = 10;
    localparam int EV_BAT_OC_ALM = 11;
    localparam int EV_OUT_OV = 12;
    localparam int EV_TEMP = 13;
    localparam int NEV = 14;
    // Events that halt the converter and clear charge enable
    localparam logic [NEV-1:0] FAULT_MASK = 14'h3_53c;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_FLAG = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam logic [7:0] OFS_DIS = 8'h10;
    localparam logic [7:0] OFS_TIME = 8'h14;
    // Control register fields
    localparam int CTRL_CHARGE_ENABLE_BIT = 0;
    localparam int CTRL_RCP_SEL_LSB = 1;
    localparam int CTRL_UC_EN = 6;
    // Timing register fields
    localparam int TIME_SS_LSB = 0;
    localparam int TIME_UCDG_LSB = 4;
    localparam int TIME_BOCDG_LSB = 8;
    // Reset values: all enabled, unmasked, cleared
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_TIME = 32'h0000_0321;
    // Soft-start step: 1 ms in ns, at 10 ns per cycle
    localparam int SS_STEP_NS = 1000000;
    localparam int CLK_NS = 10;
    localparam int SS_STEP_CYC = SS_STEP_NS / CLK_NS;
    // Interrupt low pulse length, 256 us
    localparam int INT_NS = 256000;
    localparam int INT_CYC = INT_NS / CLK_NS;
    // Repeat gap for the second adapter overvoltage interrupt
    localparam int REP_CYC = 2 * INT_CYC;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cpfl_axi_s_t;
endpackage

// >>> src/cpfl_top.sv
// Protection supervisor with AXI4-Lite register slave
// Behaviour
// - Any enabled fault trip turns off the blocking switch and halts switching.
// - Mask bits gate only the interrupt; protection still acts.
// - Disable bit holds status and flag cleared and blocks interrupt, except undercurrent.
// - Undercurrent disabled still flags and interrupts but keeps converter running.
// - Protection faults clear charge enable; host restarts full start-up.
// - Each adapter overvoltage cuts its gate drive, flags, interrupts unless masked.
// - Persistent second adapter overvoltage repeats interrupts.
// - Bus overvoltage stops conversion, clears enable, flags, interrupts.
// - Bus overcurrent stops conversion, clears enable, flags, interrupts.
// - Undercurrent after soft-start timeout stops charging when protection enabled.
// - Undercurrent with protection disabled keeps charge enable, still flags.
// - Reverse current while switching and enabled stops charging and flags.
// - Bus alarms flag and interrupt without touching charge enable.
// - High bus-to-output ratio suspends switching; resumes below falling threshold.
// - Battery overvoltage stops conversion, clears enable, flags, interrupts.
// - Battery alarms flag and interrupt; conversion continues.
// - Battery overcurrent must persist its deglitch time before tripping.
// - Output overvoltage trips unless its disable bit is set.
// - Interrupt idles high and pulses low a fixed length on new events.
// - Flags latch and clear on read; status follows live condition.
// - Persisting event after flag clear issues no further interrupt, except second adapter overvoltage.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module cpfl_top
    import cpfl_pkg::*;
#(
    parameter int SS_STEP = SS_STEP_CYC, // Soft-start step, cycles
    parameter int INT_LEN = INT_CYC, // Interrupt pulse, cycles
    parameter int REP_GAP = REP_CYC // Repeat gap, cycles
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [NEV-1:0] cmp_in, // Comparator levels per event
    input wire logic ratio_too_high, // Ratio above rising threshold
    input wire logic ratio_below_fall, // Ratio below falling threshold
    input wire logic [31:0] awaddr, // AXI write address
    input wire logic awvalid, // AXI write address valid
    input wire logic [31:0] wdata, // AXI write data
    input wire logic [3:0] wstrb, // AXI write strobes
    input wire logic wvalid, // AXI write data valid
    input wire logic bready, // AXI response ready
    input wire logic [31:0] araddr, // AXI read address
    input wire logic arvalid, // AXI read address valid
    input wire logic rready, // AXI read ready
    output cpfl_pkg::cpfl_axi_s_t axi_s, // AXI slave outputs
    output logic int_n_o, // Interrupt pin output value
    output logic int_n_oe, // Interrupt pin drive enable
    output logic [1:0] input_gate_drive, // Adapter gate drives
    output logic switch_on, // Blocking switch enable
    output logic converter_run // Converter switching enable
);
    import cpfl_pkg::*;

    // Refuse timing values the counters cannot serve
    if (SS_STEP < 1 || INT_LEN < 1 || REP_GAP <= INT_LEN) begin : g_bad
        $error("cpfl_top: bad timing parameters");
    end

    typedef struct packed {
        logic [31:0] ctrl;
        logic [NEV-1:0] stat;
        logic [NEV-1:0] flag;
        logic [NEV-1:0] mask;
        logic [NEV-1:0] dis;
        logic [11:0] tim;
        logic [NEV-1:0] seen;
        logic [NEV-1:0] live_q;
        logic [31:0] ss_cnt;
        logic ss_done;
        logic [7:0] ucdg_cnt;
        logic [7:0] bocdg_cnt;
        logic suspend;
        logic [31:0] int_cnt;
        logic [31:0] rep_cnt;
        logic aw_got;
        logic [31:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        cpfl_axi_s_t ax;
    } cpfl_state_t;

    cpfl_state_t s_reg, s_next;

    // Read mux for register offsets
    function automatic logic [32:0] reg_read(input cpfl_state_t s,
                                             input logic [31:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        unique case (a[7:0])
            OFS_CTRL: r[31:0] = s.ctrl;
            OFS_STAT: r[31:0] = {18'h0_0000, s.stat};
            OFS_FLAG: r[31:0] = {18'h0_0000, s.flag};
            OFS_MASK: r[31:0] = {18'h0_0000, s.mask};
            OFS_DIS: r[31:0] = {18'h0_0000, s.dis};
            OFS_TIME: r[31:0] = {20'h0_0000, s.tim};
            default: r[32] = 1'b0;
        endcase
        if (a[31:8] != 24'h00_0000) begin
            r = 33'h0_0000_0000;
        end
        return r;
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] st);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    logic [NEV-1:0] live;
    logic [NEV-1:0] gated;
    logic [NEV-1:0] rise;
    logic [NEV-1:0] trip;
    logic [32:0] rd;
    logic wr_fire;
    logic [31:0] ss_limit;
    logic [31:0] m;

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        m = 32'h0000_0000;
        // Soft-start timer runs while charge enable is set
        ss_limit = SS_STEP * (32'(s_reg.tim[TIME_SS_LSB +: 3]) + 32'd1);
        if (!s_reg.ctrl[CTRL_CHARGE_ENABLE_BIT]) begin
            s_next.ss_cnt = 32'h0000_0000;
            s_next.ss_done = 1'b0;
        end else if (s_reg.ss_cnt >= ss_limit) begin
            s_next.ss_done = 1'b1;
        end else begin
            s_next.ss_cnt = s_reg.ss_cnt + 32'd1;
        end
        live = cmp_in;
        // Undercurrent counted only after soft-start, with deglitch
        if (cmp_in[EV_BUS_UC] && s_reg.ss_done) begin
            if (s_reg.ucdg_cnt < {4'h0, 2'b00, s_reg.tim[TIME_UCDG_LSB +: 2]})
            begin
                s_next.ucdg_cnt = s_reg.ucdg_cnt + 8'd1;
            end
        end else begin
            s_next.ucdg_cnt = 8'h00;
        end
        live[EV_BUS_UC] = cmp_in[EV_BUS_UC] && s_reg.ss_done &&
            s_reg.ucdg_cnt >= {6'h00, s_reg.tim[TIME_UCDG_LSB +: 2]};
        // Battery overcurrent must persist its deglitch count
        if (cmp_in[EV_BAT_OC]) begin
            if (s_reg.bocdg_cnt < {4'h0, s_reg.tim[TIME_BOCDG_LSB +: 4]}) begin
                s_next.bocdg_cnt = s_reg.bocdg_cnt + 8'd1;
            end
        end else begin
            s_next.bocdg_cnt = 8'h00;
        end
        live[EV_BAT_OC] = cmp_in[EV_BAT_OC] &&
            s_reg.bocdg_cnt >= {4'h0, s_reg.tim[TIME_BOCDG_LSB +: 4]};
        // Reverse current only watched while switching
        live[EV_RCP] = cmp_in[EV_RCP] && converter_run;
        // Disable bits hold status off, except undercurrent
        gated = live & ~(s_reg.dis & ~(14'h0001 << EV_BUS_UC));
        s_next.stat = gated;
        s_next.live_q = gated;
        rise = gated & ~s_reg.live_q;
        s_next.flag = s_reg.flag | rise;
        // Faults that clear charge enable
        trip = gated & FAULT_MASK &
            ~(s_reg.dis & (14'h0001 << EV_BUS_UC));
        // Ratio suspend with hysteresis
        if (ratio_too_high) begin
            s_next.suspend = 1'b1;
        end else if (ratio_below_fall) begin
            s_next.suspend = 1'b0;
        end
        // Interrupt pulse; a persisting event never re-arms, except second adapter overvoltage
        s_next.seen = (s_reg.seen | rise) & gated;
        if (s_reg.int_cnt != 32'h0000_0000) begin
            s_next.int_cnt = s_reg.int_cnt - 32'd1;
        end
        if (s_reg.rep_cnt != 32'h0000_0000) begin
            s_next.rep_cnt = s_reg.rep_cnt - 32'd1;
        end
        if ((rise & ~s_reg.seen & ~s_reg.mask) != 14'h0000) begin
            s_next.int_cnt = 32'(INT_LEN);
        end
        if (gated[EV_ADP2_OV] && !s_reg.mask[EV_ADP2_OV] &&
            s_reg.rep_cnt == 32'h0000_0000) begin
            s_next.int_cnt = 32'(INT_LEN);
            s_next.rep_cnt = 32'(REP_GAP);
        end
        if (!gated[EV_ADP2_OV]) begin
            s_next.rep_cnt = 32'h0000_0000;
        end
        // AXI write channel capture
        if (awvalid && s_reg.ax.awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && s_reg.ax.wready) begin
            s_next.w_got = 1'b1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        s_next.ax.awready = !s_next.aw_got && !s_reg.ax.bvalid;
        s_next.ax.wready = !s_next.w_got && !s_reg.ax.bvalid;
        wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.ax.bvalid;
        rd = reg_read(s_reg, s_reg.aw_addr);
        if (wr_fire) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.ax.bvalid = 1'b1;
            s_next.ax.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
            unique case (s_reg.aw_addr[7:0])
                OFS_CTRL: s_next.ctrl = merge(s_reg.ctrl, s_reg.w_data,
                                               s_reg.w_strb);
                OFS_MASK: begin
                    m = merge({18'h0_0000, s_reg.mask}, s_reg.w_data,
                              s_reg.w_strb);
                    s_next.mask = m[NEV-1:0];
                end
                OFS_DIS: begin
                    m = merge({18'h0_0000, s_reg.dis}, s_reg.w_data,
                              s_reg.w_strb);
                    s_next.dis = m[NEV-1:0];
                end
                OFS_TIME: begin
                    m = merge({20'h0_0000, s_reg.tim}, s_reg.w_data,
                              s_reg.w_strb);
                    s_next.tim = m[11:0];
                end
                default: m = 32'h0000_0000;
            endcase
        end else begin
            m = 32'h0000_0000;
        end
        if (s_reg.ax.bvalid && bready) begin
            s_next.ax.bvalid = 1'b0;
        end
        // AXI read channel; flags clear on read, new events win
        if (arvalid && s_reg.ax.arready) begin
            rd = reg_read(s_reg, araddr);
            s_next.ax.arready = 1'b0;
            s_next.ax.rvalid = 1'b1;
            s_next.ax.rdata = rd[31:0];
            s_next.ax.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
            if (araddr == {24'h00_0000, OFS_FLAG}) begin
                s_next.flag = rise;
            end
        end
        if (s_reg.ax.rvalid && rready) begin
            s_next.ax.rvalid = 1'b0;
            s_next.ax.arready = 1'b1;
        end
        // Fault clears charge enable after any software write
        if (trip != 14'h0000) begin
            s_next.ctrl[CTRL_CHARGE_ENABLE_BIT] = 1'b0;
        end
        // Disable masks flags, except undercurrent
        s_next.flag = s_next.flag & ~(s_reg.dis & ~(14'h0001 << EV_BUS_UC));
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.tim <= RST_TIME[11:0];
            s_reg.ax.arready <= 1'b1;
            s_reg.ax.awready <= 1'b1;
            s_reg.ax.wready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs from state
    assign axi_s = s_reg.ax;
    assign int_n_o = 1'b0;
    assign int_n_oe = s_reg.int_cnt != 32'h0000_0000;
    assign input_gate_drive = ~s_reg.stat[EV_ADP2_OV:EV_ADP1_OV];
    assign switch_on = s_reg.ctrl[CTRL_CHARGE_ENABLE_BIT];
    assign converter_run = s_reg.ctrl[CTRL_CHARGE_ENABLE_BIT] && !s_reg.suspend;

    // Assertions
    a_fault_clears_en: assert property (@(posedge sys_clk) disable iff (rst)
        (trip != 14'h0000) |=> !s_reg.ctrl[CTRL_CHARGE_ENABLE_BIT])
        else $error("fault did not clear charge enable");
    a_dis_holds_stat: assert property (@(posedge sys_clk) disable iff (rst)
        s_reg.dis[EV_OUT_OV] |=> !s_reg.stat[EV_OUT_OV])
        else $error("disabled event shows status");
    a_uc_dis_keeps: assert property (@(posedge sys_clk) disable iff (rst)
        (s_reg.dis[EV_BUS_UC] && trip == 14'h0000 && !wr_fire &&
         s_reg.ctrl[CTRL_CHARGE_ENABLE_BIT]) |=> s_reg.ctrl[CTRL_CHARGE_ENABLE_BIT])
        else $error("undercurrent disabled still cleared enable");
    a_alarm_only: assert property (@(posedge sys_clk) disable iff (rst)
        (gated[EV_BAT_OV_ALM] && trip == 14'h0000 && !wr_fire &&
         s_reg.ctrl[CTRL_CHARGE_ENABLE_BIT]) |=> s_reg.ctrl[CTRL_CHARGE_ENABLE_BIT])
        else $error("alarm cleared charge enable");
    a_mask_no_int: assert property (@(posedge sys_clk) disable iff (rst)
        (!int_n_oe && (rise & ~s_reg.mask) == 14'h0000 &&
         !(gated[EV_ADP2_OV] && !s_reg.mask[EV_ADP2_OV])) |=> !int_n_oe)
        else $error("masked event pulled interrupt");
    a_int_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(int_n_oe) |-> int_n_oe [*2])
        else $error("interrupt pulse too short");
    a_suspend_run: assert property (@(posedge sys_clk) disable iff (rst)
        s_reg.suspend |-> !converter_run)
        else $error("converter runs while suspended");
    a_gate_off: assert property (@(posedge sys_clk) disable iff (rst)
        s_reg.stat[EV_ADP1_OV] |-> !input_gate_drive[0])
        else $error("gate drive on during adapter overvoltage");
    a_flag_latch: assert property (@(posedge sys_clk) disable iff (rst)
        rise[EV_BUS_OC] |=> s_reg.flag[EV_BUS_OC])
        else $error("flag not set by event");
endmodule
`default_nettype wire

// >>> testbench/cpfl_host_model.sv
// Host processor model: AXI4-Lite master and start-up sequences
`timescale 1ns/100ps
`default_nettype none
module cpfl_host_model
    import cpfl_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire cpfl_pkg::cpfl_axi_s_t axi_s, // Slave outputs
    output logic [31:0] awaddr, // Write address
    output logic awvalid, // Write address valid
    output logic [31:0] wdata, // Write data
    output logic [3:0] wstrb, // Write strobes
    output logic wvalid, // Write data valid
    output logic bready, // Response ready
    output logic [31:0] araddr, // Read address
    output logic arvalid, // Read address valid
    output logic rready // Read ready
);
    // Idle master at time zero
    initial begin
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'h0;
    end

    // One write; address and data released as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge sys_clk);
        awaddr <= {24'h00_0000, a};
        wdata <= d;
        wstrb <= 4'hf;
        {awvalid, wvalid, bready} <= 3'b111;
        while (!got) begin
            @(posedge sys_clk);
            if (awvalid && axi_s.awready) begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && axi_s.wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (axi_s.bvalid) begin
                r = axi_s.bresp;
                bready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    // One read; answer taken at the edge that shows rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge sys_clk);
        araddr <= {24'h00_0000, a};
        {arvalid, rready} <= 2'b11;
        while (!got) begin
            @(posedge sys_clk);
            if (arvalid && axi_s.arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (axi_s.rvalid) begin
                d = axi_s.rdata;
                r = axi_s.rresp;
                rready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    // Undercurrent enable first, then charge enable
    task automatic start_charge();
        logic [1:0] r;
        wr(OFS_CTRL, 32'h1 << CTRL_UC_EN, r);
        wr(OFS_CTRL, (32'h1 << CTRL_UC_EN) | 32'h1, r);
    endtask

    // Reverse select cleared before reverse disable is set
    task automatic rcp_off();
        logic [1:0] r;
        wr(OFS_CTRL, 32'h0, r);
        wr(OFS_DIS, 32'h1 << EV_RCP, r);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_charger_protection_fault_logic.sv
// Self-checking bench for the charger protection fault logic
`timescale 1ns/100ps
`default_nettype none
module tb_charger_protection_fault_logic;
    import cpfl_pkg::*;
    localparam int P_INT = 3;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [NEV-1:0] cmp_in = '0;
    logic ratio_too_high = 1'b0;
    logic ratio_below_fall = 1'b1;
    logic [31:0] awaddr, wdata, araddr, rv;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic int_n_o, int_n_oe, switch_on, converter_run;
    logic [1:0] input_gate_drive, rr;
    cpfl_axi_s_t axi_s;
    wire logic int_pin;
    int failures = 0;
    int compares = 0;
    int k;
    int faults [8] = '{EV_BUS_OV, EV_BUS_OC, EV_BUS_UC, EV_RCP, EV_BAT_OV,
                       EV_BAT_OC, EV_OUT_OV, EV_TEMP};
    int notes [5] = '{EV_ADP1_OV, EV_BUS_OV_ALM, EV_BUS_OC_ALM,
                      EV_BAT_OV_ALM, EV_BAT_OC_ALM};

    // Open-drain pin with pull-up
    assign int_pin = int_n_oe ? int_n_o : 1'b1;
    always #5 sys_clk = ~sys_clk;

    cpfl_top #(.SS_STEP(4), .INT_LEN(P_INT), .REP_GAP(8)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .cmp_in(cmp_in),
        .ratio_too_high(ratio_too_high), .ratio_below_fall(ratio_below_fall),
        .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .rready(rready), .axi_s(axi_s),
        .int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .input_gate_drive(input_gate_drive), .switch_on(switch_on),
        .converter_run(converter_run));

    cpfl_host_model u_host (
        .sys_clk(sys_clk), .axi_s(axi_s), .awaddr(awaddr),
        .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .rready(rready));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Cycles with the pin low over a window
    task automatic lows_in(input int n, output int lows);
        lows = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if (int_pin !== 1'b1) lows++;
        end
    endtask

    // Stop charging, then status must be clear and flags drained
    task automatic stop_all();
        u_host.wr(OFS_CTRL, 32'h0, rr);
        repeat (12) @(posedge sys_clk);
        u_host.rd(OFS_STAT, rv, rr);
        chk(rv, 32'h0);
        u_host.rd(OFS_FLAG, rv, rr);
    endtask

    // Raise one event while charging and check every reaction
    task automatic trip(input int e, input logic fault, input logic masked);
        int lows;
        int i;
        u_host.start_charge();
        cmp_in[e] <= 1'b1;
        lows_in(40, lows);
        chk(32'(lows), masked ? 32'd0 : 32'(P_INT));
        chk(32'(switch_on), 32'(!fault));
        chk(32'(converter_run), 32'(!fault));
        chk(32'(input_gate_drive), e == EV_ADP1_OV ? 32'd2 : 32'd3);
        u_host.rd(OFS_CTRL, rv, rr);
        chk(rv & 32'h1, 32'(!fault));
        u_host.rd(OFS_STAT, rv, rr);
        chk((rv >> e) & 32'h1,
            32'(e != EV_RCP && !(fault && e == EV_BUS_UC)));
        for (i = 0; i < 2; i++) begin
            u_host.rd(OFS_FLAG, rv, rr);
            chk((rv >> e) & 32'h1, 32'(i == 0));
        end
        lows_in(20, lows);
        chk(32'(lows), 32'd0);
        cmp_in[e] <= 1'b0;
        stop_all();
    endtask

    // Disabled source stays silent and never trips
    task automatic dis_chk(input int e);
        int lows;
        if (e == EV_RCP) u_host.rcp_off();
        else u_host.wr(OFS_DIS, 32'h1 << e, rr);
        u_host.start_charge();
        cmp_in[e] <= 1'b1;
        lows_in(40, lows);
        chk(32'(lows), 32'd0);
        chk(32'(switch_on), 32'h1);
        u_host.rd(OFS_STAT, rv, rr);
        chk(rv, 32'h0);
        u_host.rd(OFS_FLAG, rv, rr);
        chk(rv, 32'h0);
        cmp_in[e] <= 1'b0;
        u_host.wr(OFS_DIS, 32'h0, rr);
        stop_all();
    endtask

    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    // Main sequence
    initial begin
        int lows;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk(32'({int_pin, switch_on, input_gate_drive}), 32'hb);
        for (k = 0; k < 6; k++) begin
            u_host.rd(8'(4 * k), rv, rr);
            chk(rv, k == 5 ? RST_TIME : RST_ZERO);
        end
        u_host.rd(8'h18, rv, rr);
        chk({rv[29:0], rr}, {30'h0, RESP_SLVERR});
        u_host.wr(8'h18, 32'hffff_ffff, rr);
        chk(32'(rr), 32'(RESP_SLVERR));
        u_host.wr(OFS_TIME, RST_TIME, rr);
        // Short battery overcurrent blip is filtered
        u_host.start_charge();
        cmp_in[EV_BAT_OC] <= 1'b1;
        @(posedge sys_clk);
        cmp_in[EV_BAT_OC] <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk(32'(switch_on), 32'h1);
        stop_all();
        // Undercurrent ignored inside soft-start
        u_host.start_charge();
        cmp_in[EV_BUS_UC] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'(switch_on), 32'h1);
        cmp_in[EV_BUS_UC] <= 1'b0;
        stop_all();
        foreach (faults[i]) trip(faults[i], 1'b1, 1'b0);
        foreach (notes[i]) trip(notes[i], 1'b0, 1'b0);
        u_host.wr(OFS_MASK, 32'h1 << EV_BUS_OV, rr);
        trip(EV_BUS_OV, 1'b1, 1'b1);
        u_host.wr(OFS_MASK, 32'h0, rr);
        u_host.wr(OFS_DIS, 32'h1 << EV_BUS_UC, rr);
        trip(EV_BUS_UC, 1'b0, 1'b0);
        u_host.wr(OFS_DIS, 32'h0, rr);
        dis_chk(EV_BUS_OV_ALM);
        dis_chk(EV_OUT_OV);
        dis_chk(EV_RCP);
        // Second adapter repeats while present
        cmp_in[EV_ADP2_OV] <= 1'b1;
        lows_in(40, lows);
        chk(32'(lows > P_INT), 32'h1);
        chk(32'(input_gate_drive), 32'h1);
        cmp_in[EV_ADP2_OV] <= 1'b0;
        repeat (20) @(posedge sys_clk);
        stop_all();
        // Ratio hysteresis suspends and resumes switching
        u_host.start_charge();
        {ratio_too_high, ratio_below_fall} <= 2'b10;
        repeat (3) @(posedge sys_clk);
        chk(32'({switch_on, converter_run}), 32'h2);
        ratio_too_high <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(32'(converter_run), 32'h0);
        ratio_below_fall <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'({switch_on, converter_run}), 32'h3);
        stop_all();
        wrap_up();
    end
endmodule
`default_nettype wire
